/* common/qed_pkg.sv */
// constants and types for the quadrature encoder decoder
// assumes a single 40 MHz system clock and no software register access
package qed_pkg;

   // counter width and encoder geometry
   localparam int COUNT_WIDTH   = 32;
   localparam int PULSES_PER_REV = 1000;
   localparam int EDGES_PER_PULSE = 4;
   localparam int EDGES_PER_REV  = PULSES_PER_REV * EDGES_PER_PULSE;
   localparam int REV_WIDTH     = 12;
   localparam int PRIME_DEPTH   = 3; // clocks before edges are judged

   // reset values
   localparam logic [1:0] SYNC_RESET = 2'h0;

   // state of the decoder core
   typedef struct packed {
      logic [1:0] sync_a;
      logic [1:0] sync_b;
      logic [1:0] sync_z;
      logic [PRIME_DEPTH-1:0] primed;
      logic       prev_a;
      logic       prev_b;
      logic       prev_z;
      logic       cw_step;
      logic       ccw_step;
      logic       marker;
      logic       phase_error;
   } qed_dec_state_t;

endpackage : qed_pkg

/* core/qed_edge_decoder.sv */
// two-flop synchronisers and quadrature edge decoding
// assumes raw encoder pins asynchronous to clock, reset already synchronous
`timescale 1ns/100ps
module qed_edge_decoder
(
   input  wire logic clock,
   input  wire logic rst_n,
   input  wire logic phase_a,
   input  wire logic phase_b,
   input  wire logic marker_in,
   output logic      cw_step,
   output logic      ccw_step,
   output logic      marker_rise,
   output logic      phase_error
);

   qed_pkg::qed_dec_state_t state;
   qed_pkg::qed_dec_state_t next_state;

   // synchronise, then compare settled samples with the previous ones
   always_comb
   begin
      logic a;
      logic b;
      logic da;
      logic db;
      logic en;
      logic fwd;
      logic rev;
      a   = 1'b0;
      b   = 1'b0;
      da  = 1'b0;
      db  = 1'b0;
      en  = 1'b0;
      fwd = 1'b0;
      rev = 1'b0;
      next_state = state;
      next_state.sync_a = {state.sync_a[0], phase_a};
      next_state.sync_b = {state.sync_b[0], phase_b};
      next_state.sync_z = {state.sync_z[0], marker_in};
      // no edge is judged until the old samples hold real pin levels,
      // so a phase or marker already high at release is not a step
      next_state.primed = {state.primed[qed_pkg::PRIME_DEPTH-2:0], 1'b1};
      en = state.primed[qed_pkg::PRIME_DEPTH-1];
      a  = state.sync_a[1];
      b  = state.sync_b[1];
      da = a ^ state.prev_a;
      db = b ^ state.prev_b;
      next_state.prev_a = a;
      next_state.prev_b = b;
      next_state.prev_z = state.sync_z[1];
      // a single changing phase is one edge; a after b's level gives direction
      // forward (a leads): a changes to differ from b, or b changes to equal a
      fwd = (da & ~db & (a != b)) | (db & ~da & (a == b));
      rev = (da & ~db & (a == b)) | (db & ~da & (a != b));
      next_state.cw_step     = en & fwd;
      next_state.ccw_step    = en & rev;
      next_state.phase_error = en & da & db;
      next_state.marker      = en & state.sync_z[1] & ~state.prev_z;
   end

   // register the whole state
   always_ff @(posedge clock or negedge rst_n)
   begin
      if (!rst_n)
      begin
         state <= '0;
      end
      else
      begin
         state <= next_state;
      end
   end

   assign cw_step     = state.cw_step;
   assign ccw_step    = state.ccw_step;
   assign marker_rise = state.marker;
   assign phase_error = state.phase_error;

endmodule : qed_edge_decoder

/* core/qed_decoder_top.sv */
// quadrature encoder decoder top: strobes, cw/ccw counters and position
// assumes encoder pins asynchronous to clock; reset_n release is synchronised here by two flops
`timescale 1ns/100ps
module qed_decoder_top
#(
   parameter int COUNT_WIDTH = qed_pkg::COUNT_WIDTH,
   parameter int EDGES_PER_REV = qed_pkg::EDGES_PER_REV
)
(
   input  wire logic                   clock,
   input  wire logic                   reset_n,
   input  wire logic                   phase_a,
   input  wire logic                   phase_b,
   input  wire logic                   marker_in,
   output logic                        cw_pulse,
   output logic                        ccw_pulse,
   output logic                        marker_pulse,
   output logic                        phase_error,
   output logic [COUNT_WIDTH-1:0]      cw_count,
   output logic [COUNT_WIDTH-1:0]      ccw_count,
   output logic [COUNT_WIDTH-1:0]      position,
   output logic                        marker_seen,
   output logic [qed_pkg::REV_WIDTH-1:0] edges_since_marker
);

   localparam int RW = qed_pkg::REV_WIDTH;

   typedef struct packed {
      logic [1:0]             rst_sync;
      logic                   cw;
      logic                   ccw;
      logic                   mark;
      logic                   err;
      logic [COUNT_WIDTH-1:0] cw_cnt;
      logic [COUNT_WIDTH-1:0] ccw_cnt;
      logic [COUNT_WIDTH-1:0] pos;
      logic                   seen;
      logic [RW-1:0]          since;
   } qed_top_state_t;

   qed_top_state_t state;
   qed_top_state_t next_state;
   logic           rst_n;
   logic           dec_cw;
   logic           dec_ccw;
   logic           dec_mark;
   logic           dec_err;

   assign rst_n = state.rst_sync[1];

   // edge detection and direction
   qed_edge_decoder u_dec
   (
      .clock       (clock),
      .rst_n       (rst_n),
      .phase_a     (phase_a),
      .phase_b     (phase_b),
      .marker_in   (marker_in),
      .cw_step     (dec_cw),
      .ccw_step    (dec_ccw),
      .marker_rise (dec_mark),
      .phase_error (dec_err)
   );

   // counters advance straight from the strobes
   always_comb
   begin
      logic [COUNT_WIDTH-1:0] cw_n;
      logic [COUNT_WIDTH-1:0] ccw_n;
      cw_n  = state.cw_cnt;
      ccw_n = state.ccw_cnt;
      next_state = state;
      next_state.rst_sync = {state.rst_sync[0], 1'b1};
      next_state.cw   = dec_cw;
      next_state.ccw  = dec_ccw;
      next_state.mark = dec_mark;
      next_state.err  = dec_err;
      if (dec_cw)
      begin
         cw_n = state.cw_cnt + 1'b1;
      end
      if (dec_ccw)
      begin
         ccw_n = state.ccw_cnt + 1'b1;
      end
      next_state.cw_cnt  = cw_n;
      next_state.ccw_cnt = ccw_n;
      next_state.pos     = cw_n - ccw_n;
      // edge count within one turn, restarted by the marker
      if (dec_mark)
      begin
         next_state.seen  = 1'b1;
         next_state.since = '0;
      end
      else if ((dec_cw | dec_ccw) && state.since
               != RW'(EDGES_PER_REV - 1))
      begin
         next_state.since = state.since + 1'b1;
      end
      else if (dec_cw | dec_ccw)
      begin
         next_state.since = '0; // wraps once per turn
      end
      // the core stays cleared until the release has passed both flops
      if (!rst_n)
      begin
         next_state          = '0;
         next_state.rst_sync = {state.rst_sync[0], 1'b1};
      end
   end

   // one register for all state; the raw pin clears it at once,
   // release then waits for the two synchroniser flops
   always_ff @(posedge clock or negedge reset_n)
   begin
      if (!reset_n)
      begin
         state <= '0;
      end
      else
      begin
         state <= next_state;
      end
   end

   assign cw_pulse           = state.cw;
   assign ccw_pulse          = state.ccw;
   assign marker_pulse       = state.mark;
   assign phase_error        = state.err;
   assign cw_count           = state.cw_cnt;
   assign ccw_count          = state.ccw_cnt;
   assign position           = state.pos;
   assign marker_seen        = state.seen;
   assign edges_since_marker = state.since;

endmodule : qed_decoder_top

/* verif/qed_monitor.sv */
// checker on the decoder top ports
// assumes one clock; bound into the top below
`timescale 1ns/100ps
module qed_monitor
#(
   parameter int COUNT_WIDTH = 32
)
(
   input wire logic                   clock,
   input wire logic                   reset_n,
   input wire logic                   phase_a,
   input wire logic                   phase_b,
   input wire logic                   cw_pulse,
   input wire logic                   ccw_pulse,
   input wire logic                   phase_error,
   input wire logic [COUNT_WIDTH-1:0] cw_count,
   input wire logic [COUNT_WIDTH-1:0] ccw_count,
   input wire logic [COUNT_WIDTH-1:0] position
);
   logic pa;
   logic pb;
   logic ca;
   logic cb;
   logic one_ch;
   // phases seen at the previous edge
   always_ff @(posedge clock)
   begin
      pa <= phase_a;
      pb <= phase_b;
   end
   // which phase moved since then
   assign ca = phase_a ^ pa;
   assign cb = phase_b ^ pb;
   assign one_ch = ca ^ cb;
   default clocking dc @(posedge clock); endclocking
   default disable iff (!reset_n);
   fwd_step_a: assert property (one_ch && ca == (phase_a ^ phase_b)
      |-> ##[4:5] cw_pulse && !ccw_pulse) else $error("fwd step lost");
   rev_step_a: assert property (one_ch && ca != (phase_a ^ phase_b)
      |-> ##[4:5] ccw_pulse && !cw_pulse) else $error("rev step lost");
   one_dir_a: assert property (!(cw_pulse && ccw_pulse))
      else $error("both strobes high");
   pulse_cause_a: assert property (cw_pulse || ccw_pulse
      |-> $past(one_ch, 4) || $past(one_ch, 5)) else $error("stray strobe");
   cw_tally_a: assert property (cw_count - $past(cw_count)
      == COUNT_WIDTH'(cw_pulse)) else $error("cw count off");
   ccw_tally_a: assert property (ccw_count - $past(ccw_count)
      == COUNT_WIDTH'(ccw_pulse)) else $error("ccw count off");
   pos_diff_a: assert property (position == cw_count - ccw_count)
      else $error("position off");
   both_change_a: assert property (ca && cb
      |-> ##[4:5] phase_error && !cw_pulse && !ccw_pulse)
      else $error("double change counted");
endmodule : qed_monitor

bind qed_decoder_top qed_monitor #(.COUNT_WIDTH(COUNT_WIDTH)) mon_u (.clock,
   .reset_n, .phase_a, .phase_b, .cw_pulse, .ccw_pulse, .phase_error,
   .cw_count, .ccw_count, .position);

/* verif/qed_encoder_model.sv */
// behavioural rotary encoder for the decoder pins
// assumes step requests held one clock, spaced apart
`timescale 1ns/100ps
module qed_encoder_model
#(
   parameter int EDGES_PER_REV = 8
)
(
   input  wire logic clock,
   input  wire logic step_req,
   input  wire logic step_fwd,
   input  wire logic jump_req,
   output logic      phase_a,
   output logic      phase_b,
   output logic      marker_in
);
   int unsigned pos = 0;
   // edge position in the turn; a jump moves both phases at once
   always @(posedge clock)
   begin
      if (jump_req)
         pos <= (pos + 2) % EDGES_PER_REV;
      else if (step_req)
         pos <= (pos + (step_fwd ? 1 : EDGES_PER_REV - 1)) % EDGES_PER_REV;
   end
   // forward stepping has phase a leading
   assign phase_a = pos[0] ^ pos[1];
   assign phase_b = pos[1];
   assign marker_in = (pos == 0);
endmodule : qed_encoder_model

/* verif/quadrature_encoder_decoder_bench.sv */
// self-checking bench for the quadrature decoder
// assumes the encoder model and the bound checker
`timescale 1ns/100ps
module quadrature_encoder_decoder_bench;
   logic        clock = 1'b0;
   logic        reset_n = 1'b0;
   logic        step_req = 1'b0;
   logic        step_fwd = 1'b0;
   logic        jump_req = 1'b0;
   logic        phase_a, phase_b, marker_in, cw_pulse, ccw_pulse;
   logic        phase_error, marker_seen, marker_pulse;
   logic [11:0] edges_since_marker;
   logic [31:0] cw_count, ccw_count, position;
   int          bad_count = 0, total_checks = 0;
   int          exp_cw = 0, exp_ccw = 0, errs = 0, marks = 0;
   // clock and tallies of refused steps and marker pulses
   always #12.5 clock = ~clock;
   always @(posedge clock) if (phase_error === 1'b1) errs <= errs + 1;
   always @(posedge clock) if (marker_pulse === 1'b1) marks <= marks + 1;
   qed_encoder_model #(.EDGES_PER_REV(8)) enc_u (.clock, .step_req,
      .step_fwd, .jump_req, .phase_a, .phase_b, .marker_in);
   qed_decoder_top #(.EDGES_PER_REV(8)) dut_u (.clock, .reset_n, .phase_a,
      .phase_b, .marker_in, .cw_pulse, .ccw_pulse, .marker_pulse,
      .phase_error, .cw_count, .ccw_count, .position, .marker_seen,
      .edges_since_marker);
   task automatic check(string name, logic [31:0] seen, logic [31:0] exp);
      total_checks++;
      if (seen !== exp)
      begin
         $display("Error %s expected %h seen %h", name, exp, seen);
         bad_count++;
      end
   endtask : check
   task automatic step(logic fwd);
      @(posedge clock);
      step_req <= 1'b1;
      step_fwd <= fwd;
      @(posedge clock);
      step_req <= 1'b0;
      repeat (2) @(posedge clock);
      exp_cw += fwd;
      exp_ccw += !fwd;
   endtask : step
   task automatic counts();
      repeat (8) @(posedge clock);
      check("cw_count", cw_count, exp_cw);
      check("ccw_count", ccw_count, exp_ccw);
      check("position", position, exp_cw - exp_ccw);
   endtask : counts
   task automatic test_forward();
      int m0;
      m0 = marks;
      repeat (9) step(1'b1);
      counts();
      check("marker_seen", marker_seen, 1);
      check("marker_pulse", marks - m0, 1);
      check("edges_since_marker", edges_since_marker, 1);
      $display("forward test done");
   endtask : test_forward
   task automatic test_reverse();
      int m0;
      m0 = marks;
      repeat (12) step(1'b0);
      step(1'b1);
      step(1'b0);
      counts();
      check("marker_pulse", marks - m0, 2);
      check("edges_since_marker", edges_since_marker, 5);
      $display("reversal test done");
   endtask : test_reverse
   task automatic test_fault();
      int e0;
      int m0;
      e0 = errs;
      m0 = marks;
      @(posedge clock);
      jump_req <= 1'b1;
      @(posedge clock);
      jump_req <= 1'b0;
      counts();
      check("phase_error", errs, e0 + 1);
      check("edges_since_marker", edges_since_marker, 5);
      step(1'b1);
      counts();
      check("marker_pulse", marks - m0, 1);
      check("edges_since_marker", edges_since_marker, 0);
      $display("fault test done");
   endtask : test_fault
   task automatic test_reset();
      @(posedge clock);
      reset_n <= 1'b0;
      repeat (2) @(posedge clock);
      check("cw_count", cw_count, 0);
      check("ccw_count", ccw_count, 0);
      check("position", position, 0);
      reset_n <= 1'b1;
      exp_cw = 0;
      exp_ccw = 0;
      repeat (6) @(posedge clock);
      check("marker_seen", marker_seen, 0);
      step(1'b1);
      step(1'b0);
      step(1'b0);
      counts();
      $display("reset test done");
   endtask : test_reset
   task automatic conclude();
      $display("checks %0d mismatches %0d", total_checks, bad_count);
      if (bad_count == 0 && total_checks > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask : conclude
   // reset, then the scenarios in turn
   initial
   begin
      repeat (20) @(posedge clock);
      reset_n <= 1'b1;
      repeat (6) @(posedge clock);
      test_forward();
      test_reverse();
      test_fault();
      test_reset();
      conclude();
   end
   // watchdog cuts a hang short
   initial
   begin
      repeat (2000) @(posedge clock);
      bad_count++;
      conclude();
   end
endmodule : quadrature_encoder_decoder_bench
